// >>> core/sil_hist_mem.sv
/*
 * Sample history memory for the sliding average.
 * Assumes one clock; read data appear one cycle after the address.
 */
module sil_hist_mem #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32,
   parameter int unsigned AW    = 5
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem_q [DEPTH];

   // storage, no reset needed
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem_q[waddr] <= wdata;
      end
   end

   // registered read port
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= mem_q[raddr];
      end
   end

endmodule : sil_hist_mem

// >>> core/sil_top.sv
/*
 * Status indicator logic: signal, busy, error and direction lamps, the
 * status line, averaged velocity and an APB register file with interrupt.
 * Assumes measurement inputs come from logic on pclk; the standby pin is
 * asynchronous and synchronised here.
 */
`include "sil_map.svh"

module sil_top #(
   parameter int unsigned UPDATE_CYC = `SIL_UPDATE_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        signal_present,
   input  wire logic        signal_quality_ok,
   input  wire logic [15:0] velocity,
   input  wire logic [15:0] meas_rate,
   input  wire logic        standby_pin,
   input  wire logic        dir_fwd_det,
   input  wire logic        dir_bwd_det,
   input  wire logic        fatal_err,
   input  wire logic        critical_err,
   input  wire logic        param_err,
   input  wire logic        transfer_err,
   output logic             lamp_sig_red,
   output logic             lamp_sig_yellow,
   output logic             lamp_sig_green,
   output logic             lamp_busy,
   output logic             lamp_err,
   output logic             lamp_fwd,
   output logic             lamp_bwd,
   output logic             status_out,
   output logic             irq
);

   localparam int unsigned DIV_W = $clog2(UPDATE_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [31:0]            ctrl_q, ctrl_d;
   logic [15:0]            min_velocity_threshold_q, min_velocity_threshold_d;
   logic [15:0]            vmax_q, vmax_d;
   logic [15:0]            rmin_q, rmin_d;
   logic [15:0]            rmax_q, rmax_d;
   logic [`SIL_EV_W-1:0]   sts_q, sts_d;
   logic [`SIL_EV_W-1:0]   mask_q, mask_d;
   logic [`SIL_EV_W-1:0]   ev;
   logic                   init_q, init_d;
   logic                   fatal_prev_q, param_prev_q;
   logic [31:0]            prdata_d;
   logic                   pready_d, pslverr_d, irq_d;
   logic                   acc_wr, flush;
   logic [4:0]             depth_m1;

   // averager state
   sil_pkg::sil_avg_st_t   st_q, st_d;
   logic [4:0]             ptr_q, ptr_d;
   logic [5:0]             fill_q, fill_d;
   logic [20:0]            sum_q, sum_d;
   logic [15:0]            avg_q, avg_d;
   logic [15:0]            sample_q, sample_d;
   logic [15:0]            old_sample, hist_rdata;
   logic                   hist_we;

   // lamp state
   logic                   stby_s1_q, stby_s2_q;
   logic [DIV_W-1:0]       div_q, div_d;
   logic                   tick;
   logic [10:0]            flash_q, flash_d;
   logic                   phase_q, phase_d;
   logic [10:0]            brief_q, brief_d;
   sil_pkg::sil_colour_t   colour;
   logic                   standby, rate_bad, plaus_bad;
   logic                   busy_d, err_d, fwd_d, bwd_d;

   assign depth_m1 = ctrl_q[`SIL_CTRL_DEPTH_MSB:`SIL_CTRL_DEPTH_LSB];
   assign acc_wr   = psel & penable & pready & pwrite;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, decode in the wait cycle, write at completion
   always_comb
   begin
      ctrl_d    = ctrl_q;
      min_velocity_threshold_d = min_velocity_threshold_q;
      vmax_d    = vmax_q;
      rmin_d    = rmin_q;
      rmax_d    = rmax_q;
      mask_d    = mask_q;
      init_d    = init_q;
      flush     = 1'b0;
      prdata_d  = prdata;
      pslverr_d = 1'b0;
      pready_d  = psel & penable & ~pready;
      ev        = '0;
      ev[`SIL_EV_FATAL]    = fatal_err & ~fatal_prev_q;
      ev[`SIL_EV_CRITICAL] = critical_err;
      ev[`SIL_EV_PARAM]    = param_err & ~param_prev_q;
      ev[`SIL_EV_TRANSFER] = transfer_err;
      sts_d     = sts_q;
      if (psel && penable && !pready)
      begin
         prdata_d = 32'h0000_0000;
         unique case (paddr)
            `SIL_OFF_CTRL:     prdata_d = ctrl_q;
            `SIL_OFF_MIN_VEL:  prdata_d = {16'h0000, min_velocity_threshold_q};
            `SIL_OFF_LIMIT:    prdata_d = {16'h0000, vmax_q};
            `SIL_OFF_RATE:     prdata_d = {rmax_q, rmin_q};
            `SIL_OFF_IRQ_STAT: prdata_d = {28'h0000000, sts_q};
            `SIL_OFF_IRQ_MASK: prdata_d = {28'h0000000, mask_q};
            `SIL_OFF_STATE:    prdata_d = {avg_q, 6'h00, init_q, standby,
                                           status_out, lamp_bwd, lamp_fwd,
                                           lamp_err, lamp_busy,
                                           lamp_sig_green, lamp_sig_yellow,
                                           lamp_sig_red};
            default:           pslverr_d = 1'b1;
         endcase
         if (pwrite)
         begin
            prdata_d = 32'h0000_0000;
         end
      end
      if (acc_wr)
      begin
         unique case (paddr)
            `SIL_OFF_CTRL:
            begin
               ctrl_d = {19'h00000, pwdata[12:8], 1'b0, pwdata[6:0]};
               // depth change restarts the window
               flush  = (pwdata[12:8] != depth_m1) | pwdata[`SIL_CTRL_RESTART];
               if (pwdata[`SIL_CTRL_INIT_DONE])
               begin
                  init_d = 1'b0;
               end
               if (pwdata[`SIL_CTRL_RESTART])
               begin
                  init_d = 1'b1;                            // restart
               end
            end
            `SIL_OFF_MIN_VEL:  min_velocity_threshold_d = pwdata[15:0];
            `SIL_OFF_LIMIT:    vmax_d = pwdata[15:0];
            `SIL_OFF_RATE:
            begin
               rmin_d = pwdata[15:0];
               rmax_d = pwdata[31:16];
            end
            `SIL_OFF_IRQ_STAT: sts_d = sts_q & ~pwdata[`SIL_EV_W-1:0];
            `SIL_OFF_IRQ_MASK: mask_d = pwdata[`SIL_EV_W-1:0];
            default:           sts_d = sts_q;
         endcase
      end
      sts_d = sts_d | ev;                                   // set wins over clear
      irq_d = |(sts_d & mask_d);
   end

   // register file flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q       <= `SIL_CTRL_RST;
         min_velocity_threshold_q <= `SIL_MIN_VEL_RST;
         vmax_q       <= `SIL_VMAX_RST;
         rmin_q       <= `SIL_RMIN_RST;
         rmax_q       <= `SIL_RMAX_RST;
         sts_q        <= '0;
         mask_q       <= '0;
         init_q       <= 1'b1;
         fatal_prev_q <= 1'b0;
         param_prev_q <= 1'b0;
         prdata       <= 32'h0000_0000;
         pready       <= 1'b0;
         pslverr      <= 1'b0;
         irq          <= 1'b0;
      end
      else
      begin
         ctrl_q       <= ctrl_d;
         min_velocity_threshold_q <= min_velocity_threshold_d;
         vmax_q       <= vmax_d;
         rmin_q       <= rmin_d;
         rmax_q       <= rmax_d;
         sts_q        <= sts_d;
         mask_q       <= mask_d;
         init_q       <= init_d;
         fatal_prev_q <= fatal_err;
         param_prev_q <= param_err;
         prdata       <= prdata_d;
         pready       <= pready_d;
         pslverr      <= pslverr_d;
         irq          <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sliding average over 1 to 32 samples, one sample per update tick
   assign old_sample = (fill_q == {1'b0, depth_m1} + 6'h01) ? hist_rdata : 16'h0000;

   always_comb
   begin
      st_d     = st_q;
      ptr_d    = ptr_q;
      fill_d   = fill_q;
      sum_d    = sum_q;
      avg_d    = avg_q;
      sample_d = sample_q;
      hist_we  = 1'b0;
      if (flush)
      begin
         st_d   = sil_pkg::SIL_AVG_IDLE;
         ptr_d  = 5'h00;
         fill_d = 6'h00;
         sum_d  = 21'h000000;
      end
      else
      begin
         unique case (st_q)
            sil_pkg::SIL_AVG_IDLE:
            begin
               if (tick)
               begin
                  sample_d = velocity;
                  st_d     = sil_pkg::SIL_AVG_FETCH;
               end
            end
            sil_pkg::SIL_AVG_FETCH:
            begin
               hist_we = 1'b1;
               sum_d   = sum_q + {5'h00, sample_q} - {5'h00, old_sample};
               if (old_sample == 16'h0000 && fill_q != {1'b0, depth_m1} + 6'h01)
               begin
                  fill_d = fill_q + 6'h01;
               end
               ptr_d = (ptr_q == depth_m1) ? 5'h00 : ptr_q + 5'h01;
               avg_d = 16'(sum_d / {15'h0000, fill_d});
               st_d  = sil_pkg::SIL_AVG_IDLE;
            end
         endcase
      end
   end

   // averager flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q     <= sil_pkg::SIL_AVG_IDLE;
         ptr_q    <= 5'h00;
         fill_q   <= 6'h00;
         sum_q    <= 21'h000000;
         avg_q    <= 16'h0000;
         sample_q <= 16'h0000;
      end
      else
      begin
         st_q     <= st_d;
         ptr_q    <= ptr_d;
         fill_q   <= fill_d;
         sum_q    <= sum_d;
         avg_q    <= avg_d;
         sample_q <= sample_d;
      end
   end

   // history of the last samples
   sil_hist_mem #(
      .WIDTH (16),
      .DEPTH (32),
      .AW    (5)
   ) u_hist (
      .clk   (pclk),
      .rst_n (presetn),
      .we    (hist_we),
      .waddr (ptr_q),
      .wdata (sample_q),
      .raddr (ptr_q),
      .rdata (hist_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // lamp logic: update divider, flash phase, brief error pulse
   assign tick      = (div_q == DIV_W'(UPDATE_CYC - 1));
   assign standby   = ctrl_q[`SIL_CTRL_STANDBY] | stby_s2_q;
   assign rate_bad  = ctrl_q[`SIL_CTRL_RATE_MON] & (meas_rate < rmin_q);
   assign plaus_bad = ctrl_q[`SIL_CTRL_PLAUS] & ((avg_q > vmax_q) | (meas_rate > rmax_q));

   always_comb
   begin
      div_d   = tick ? '0 : div_q + DIV_W'(1);
      flash_d = flash_q;
      phase_d = phase_q;
      brief_d = brief_q;
      if (tick)
      begin
         flash_d = flash_q + 11'h001;
         if (flash_q == 11'(`SIL_FLASH_TICKS - 1))
         begin
            flash_d = 11'h000;
            phase_d = ~phase_q;
         end
         if (brief_q != 11'h000)
         begin
            brief_d = brief_q - 11'h001;
         end
      end
      if (critical_err || transfer_err || ev[`SIL_EV_PARAM])
      begin
         brief_d = 11'(`SIL_BRIEF_TICKS);                   // brief flash
      end
      // one colour: yellow while initialising, otherwise red over yellow over green
      if (init_q)
      begin
         colour = sil_pkg::SIL_YELLOW;
      end
      else if (!signal_present || rate_bad || plaus_bad)
      begin
         colour = sil_pkg::SIL_RED;
      end
      else if (avg_q < min_velocity_threshold_q)
      begin
         colour = sil_pkg::SIL_YELLOW;
      end
      else if (signal_quality_ok)
      begin
         colour = sil_pkg::SIL_GREEN;
      end
      else
      begin
         colour = sil_pkg::SIL_RED;
      end
      busy_d = init_q | (standby ? phase_q
                                 : ctrl_q[`SIL_CTRL_CMD_BUSY]);
      err_d  = init_q | (fatal_err ? phase_q
                                   : (brief_q != 11'h000) | param_err);
      fwd_d  = ~init_q & (ctrl_q[`SIL_CTRL_AUTO_DIR] ? dir_fwd_det
                                                     : ~ctrl_q[`SIL_CTRL_DIR_BWD]);
      bwd_d  = ~init_q & (ctrl_q[`SIL_CTRL_AUTO_DIR] ? dir_bwd_det
                                                     : ctrl_q[`SIL_CTRL_DIR_BWD]);
   end

   // lamp flops and standby pin synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stby_s1_q       <= 1'b0;
         stby_s2_q       <= 1'b0;
         div_q           <= '0;
         flash_q         <= 11'h000;
         phase_q         <= 1'b0;
         brief_q         <= 11'h000;
         lamp_sig_red    <= 1'b0;
         lamp_sig_yellow <= 1'b1;
         lamp_sig_green  <= 1'b0;
         lamp_busy       <= 1'b1;
         lamp_err        <= 1'b1;
         lamp_fwd        <= 1'b0;
         lamp_bwd        <= 1'b0;
         status_out      <= 1'b0;
      end
      else
      begin
         stby_s1_q       <= standby_pin;
         stby_s2_q       <= stby_s1_q;
         div_q           <= div_d;
         flash_q         <= flash_d;
         phase_q         <= phase_d;
         brief_q         <= brief_d;
         lamp_sig_red    <= (colour == sil_pkg::SIL_RED);
         lamp_sig_yellow <= (colour == sil_pkg::SIL_YELLOW);
         lamp_sig_green  <= (colour == sil_pkg::SIL_GREEN);
         lamp_busy       <= busy_d;
         lamp_err        <= err_d;
         lamp_fwd        <= fwd_d;
         lamp_bwd        <= bwd_d;
         status_out      <= (colour == sil_pkg::SIL_GREEN);
      end
   end

endmodule : sil_top

// >>> inc/sil_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * status indicator logic.
 * Assumes a 25 MHz pclk and byte addressed 32-bit APB words.
 */
// How it works
// - The signal lamp is green while the object moves and signal quality is sufficient.
// - The signal lamp is yellow when a signal exists but the velocity is below the minimum.
// - The signal lamp is red whenever neither the green nor the yellow condition holds.
// - With rate monitoring on, a measurement rate below its threshold forces red.
// - With plausibility control on, velocity or rate out of range forces red.
// - The status output is on while the signal lamp is green and off otherwise.
// - The busy lamp is lit while a command, calibration, simulation or standby runs.
// - The busy lamp flashes during standby, whether by command or by the standby pin.
// - The error lamp flashes steadily on a fatal error and briefly on a critical one.
// - The error lamp also lights, briefly or steadily, on bad parameters or transfer errors.
// - During initialisation signal and busy lamps show yellow and the error lamp red.
// - The forward lamp is green for a set forward direction or a detected forward movement.
// - The backward lamp is green for a set backward direction or a detected backward one.
// - Velocity is updated every 0.2 ms through a sliding average of 1 to 32 samples.
`ifndef SIL_MAP_SVH
`define SIL_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define SIL_OFF_CTRL      12'h000
`define SIL_OFF_MIN_VEL   12'h004
`define SIL_OFF_LIMIT     12'h008
`define SIL_OFF_RATE      12'h00c
`define SIL_OFF_IRQ_STAT  12'h010
`define SIL_OFF_IRQ_MASK  12'h014
`define SIL_OFF_STATE     12'h018

////////////////////////////////////////////////////////////////////////////////
// control register fields
`define SIL_CTRL_RATE_MON   0
`define SIL_CTRL_PLAUS      1
`define SIL_CTRL_AUTO_DIR   2
`define SIL_CTRL_DIR_BWD    3
`define SIL_CTRL_CMD_BUSY   4
`define SIL_CTRL_STANDBY    5
`define SIL_CTRL_INIT_DONE  6
`define SIL_CTRL_RESTART    7
`define SIL_CTRL_DEPTH_LSB  8
`define SIL_CTRL_DEPTH_MSB  12
`define SIL_CTRL_RST        32'h0000_0000

// event bits of the status and mask registers
`define SIL_EV_FATAL     0
`define SIL_EV_CRITICAL  1
`define SIL_EV_PARAM     2
`define SIL_EV_TRANSFER  3
`define SIL_EV_W         4

`define SIL_MIN_VEL_RST  16'h0000
`define SIL_VMAX_RST     16'hffff
`define SIL_RMIN_RST     16'h0000
`define SIL_RMAX_RST     16'hffff

////////////////////////////////////////////////////////////////////////////////
// timing
`define SIL_CLK_NS         40
`define SIL_UPDATE_NS      200000
`define SIL_UPDATE_CYC     ((`SIL_UPDATE_NS + `SIL_CLK_NS - 1) / `SIL_CLK_NS)
`define SIL_FLASH_HALF_NS  250000000
`define SIL_FLASH_TICKS    (`SIL_FLASH_HALF_NS / `SIL_UPDATE_NS)
`define SIL_BRIEF_NS       100000000
`define SIL_BRIEF_TICKS    (`SIL_BRIEF_NS / `SIL_UPDATE_NS)

`endif

// >>> inc/sil_pkg.sv
/*
 * Types of the status indicator logic.
 * Assumes sil_map.svh carries all numeric constants.
 */
package sil_pkg;

   // signal lamp colour, one lamp at a time
   typedef enum logic [1:0] {
      SIL_RED    = 2'b00,
      SIL_YELLOW = 2'b01,
      SIL_GREEN  = 2'b10
   } sil_colour_t;

   // sliding average sequencer
   typedef enum logic [0:0] {
      SIL_AVG_IDLE  = 1'b0,
      SIL_AVG_FETCH = 1'b1
   } sil_avg_st_t;

endpackage : sil_pkg

// >>> tb/sil_plant.sv
/* plant side: standby switch and controller status input
   assumes a request from the bench and the status line */
module sil_plant (
   input wire logic pclk,
   input wire logic standby_req,
   input wire logic status_out,
   output logic     standby_pin,
   output logic     status_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   // external standby level and the controller's view of status
   always_ff @(posedge pclk)
   begin
      standby_pin <= standby_req;
      status_seen <= status_out;
   end
endmodule : sil_plant

// >>> tb/sil_top_monitor.sv
/* checker of the indicator lamps of sil_top
   assumes only the top ports; bound after the module */
module sil_top_monitor #(
   parameter int unsigned UPDATE_CYC = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic signal_present,
   input wire logic standby_pin,
   input wire logic fatal_err,
   input wire logic critical_err,
   input wire logic param_err,
   input wire logic transfer_err,
   input wire logic lamp_sig_red,
   input wire logic lamp_sig_yellow,
   input wire logic lamp_sig_green,
   input wire logic lamp_busy,
   input wire logic lamp_err,
   input wire logic status_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned LIM = 1250 * UPDATE_CYC + 8;
   logic [31:0] ecnt_q, ecnt_d, bcnt_q, bcnt_d;
   logic        err_q, busy_q;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   // run length of a lamp that should be flashing
   always_comb
   begin
      ecnt_d = (fatal_err && lamp_err == err_q) ? ecnt_q + 32'h1 : 32'h0;
      bcnt_d = (standby_pin && lamp_busy == busy_q) ? bcnt_q + 32'h1 : 32'h0;
   end
   // registers of the run counters
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ecnt_q <= 32'h0;
         bcnt_q <= 32'h0;
         err_q  <= 1'h0;
         busy_q <= 1'h0;
      end
      else
      begin
         ecnt_q <= ecnt_d;
         bcnt_q <= bcnt_d;
         err_q  <= lamp_err;
         busy_q <= lamp_busy;
      end
   end
   ////////////////////////////////////////
   property p_init;
      $rose(presetn) |-> lamp_sig_yellow && lamp_busy && lamp_err;
   endproperty
   a_init: assert property (p_init) else $error("init lamps wrong");
   property p_one;
      $onehot({lamp_sig_red, lamp_sig_yellow, lamp_sig_green});
   endproperty
   a_one: assert property (p_one) else $error("not one colour");
   property p_status;
      status_out == lamp_sig_green;
   endproperty
   a_status: assert property (p_status) else $error("status differs");
   property p_green;
      !signal_present |=> !lamp_sig_green;
   endproperty
   a_green: assert property (p_green) else $error("green without signal");
   property p_red;
      !signal_present |=> lamp_sig_red || (lamp_busy && lamp_err);
   endproperty
   a_red: assert property (p_red) else $error("no red without signal");
   property p_crit;
      critical_err && !fatal_err |-> ##[1:2] lamp_err;
   endproperty
   a_crit: assert property (p_crit) else $error("no brief flash");
   property p_param;
      param_err && !fatal_err |-> ##[1:2] lamp_err;
   endproperty
   a_param: assert property (p_param) else $error("param error unseen");
   property p_xfer;
      transfer_err && !fatal_err |-> ##[1:2] lamp_err;
   endproperty
   a_xfer: assert property (p_xfer) else $error("transfer error unseen");
   property p_fatal;
      ecnt_q <= LIM;
   endproperty
   a_fatal: assert property (p_fatal) else $error("error lamp not flashing");
   property p_stby;
      bcnt_q <= LIM;
   endproperty
   a_stby: assert property (p_stby) else $error("busy lamp not flashing");
endmodule : sil_top_monitor

bind sil_top sil_top_monitor #(.UPDATE_CYC(UPDATE_CYC)) u_mon (.pclk(pclk),
   .presetn(presetn), .signal_present(signal_present), .standby_pin(standby_pin),
   .fatal_err(fatal_err), .critical_err(critical_err), .param_err(param_err),
   .transfer_err(transfer_err), .lamp_sig_red(lamp_sig_red),
   .lamp_sig_yellow(lamp_sig_yellow), .lamp_sig_green(lamp_sig_green),
   .lamp_busy(lamp_busy), .lamp_err(lamp_err), .status_out(status_out));

// >>> tb/testbench.sv
/* self-checking bench of sil_top
   assumes sil_top_monitor and sil_plant compiled before */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned UC = 8;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, se, spin, sseen, pb, pe;
   logic sp = 1'h0, q = 1'h0, fdet = 1'h0, bdet = 1'h0, fatal = 1'h0, sreq = 1'h0, am = 1'h0;
   logic [2:0]  ev = 3'h0, e;
   logic [15:0] vel = 16'h0, rate = 16'h0, min_vel, vp = 16'h0;
   logic        red, yel, grn, busy, err, fwd, bwd, stat, irq;
   int          errors = 0, n_checks = 0, seed = 63, i, n, nb, ne, tc = 0;
   always #20 pclk = ~pclk;
   // velocity pattern of four windows, one update tick in each
   always @(posedge pclk)
   begin
      tc <= tc + 1;
      vp <= 16'h0001 + 16'h1001 * 16'(tc / UC % 4);
   end
   sil_plant u_plant (.pclk(pclk), .standby_req(sreq), .status_out(stat),
      .standby_pin(spin), .status_seen(sseen));
   sil_top #(.UPDATE_CYC(UC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .signal_present(sp),
      .signal_quality_ok(q), .velocity(am ? vp : vel), .meas_rate(rate), .standby_pin(spin),
      .dir_fwd_det(fdet), .dir_bwd_det(bdet), .fatal_err(fatal),
      .critical_err(ev[0]), .param_err(ev[2]), .transfer_err(ev[1]),
      .lamp_sig_red(red), .lamp_sig_yellow(yel), .lamp_sig_green(grn),
      .lamp_busy(busy), .lamp_err(err), .lamp_fwd(fwd), .lamp_bwd(bwd),
      .status_out(stat), .irq(irq));
   ////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   // compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      for (k = 0; k < 16; k++)
      begin
         @(posedge pclk);
         if (pready === 1'h1)
            break;
      end
      if (k == 16)
      begin
         errors++;
         complete_run;
      end
      rd = prdata;
      se = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask : cyc
   // one-cycle event pulse, bits param, transfer, critical
   task automatic pulse(input logic [2:0] m);
      @(posedge pclk);
      ev <= m;
      @(posedge pclk);
      ev <= 3'h0;
   endtask : pulse
   // expected colour as green, yellow, red
   function automatic logic [2:0] col(input logic s, input logic g, input logic [1:0] en);
      if (!s || (en[0] && rate < 16'h0100) || (en[1] && (vel > 16'hc000 || rate > 16'hf000)))
         return 3'h1;
      if (vel < min_vel)
         return 3'h2;
      return g ? 3'h4 : 3'h1;
   endfunction : col
   ////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      chk("init lamps", {busy, err, grn, yel, red}, 32'h1a);
      apb(1'h0, 12'h000, 32'h0);
      chk("ctrl", rd, 32'h0);
      apb(1'h0, 12'h008, 32'h0);
      chk("limit", rd, 32'hffff);
      apb(1'h0, 12'h00c, 32'h0);
      chk("rate", rd, 32'hffff0000);
      $display("reset test done");
      apb(1'h1, 12'h008, 32'hc000);
      apb(1'h1, 12'h00c, 32'hf0000100);
      for (i = 0; i < 14; i++)
      begin
         n = $random(seed);
         min_vel = $random(seed);
         apb(1'h1, 12'h004, {16'h0, min_vel});
         apb(1'h1, 12'h000, {25'h0, 1'h1, 4'h0, n[1], n[0] | (i < 2)});
         sp <= n[2] | n[5];
         q <= n[3] | n[6];
         vel <= (i == 0) ? min_vel : 16'($random(seed));
         rate <= (i < 2) ? 16'h00ff + 16'(i) : 16'($random(seed));
         cyc(4 * UC);
         e = col(sp, q, {n[1], n[0] | (i < 2)});
         chk("signal lamps", {grn, yel, red}, e);
         chk("status", {stat, sseen}, {2{e[2]}});
      end
      $display("colour test done");
      for (i = 0; i < 8; i++)
      begin
         n = $random(seed);
         apb(1'h1, 12'h000, {25'h0, 1'h1, 2'h0, n[1:0], 2'h0});
         fdet <= n[2];
         bdet <= n[3];
         cyc(3);
         chk("direction", {fwd, bwd}, n[0] ? {n[2], n[3]} : {~n[1], n[1]});
      end
      apb(1'h1, 12'h000, 32'h50);
      cyc(3);
      chk("busy", busy, 1'h1);
      apb(1'h1, 12'h000, 32'h40);
      cyc(3);
      chk("busy", busy, 1'h0);
      $display("direction and busy test done");
      apb(1'h1, 12'h014, 32'hf);
      pulse(3'h4);
      cyc(3);
      chk("irq and error", {irq, err}, 2'h3);
      apb(1'h0, 12'h010, 32'h0);
      chk("event status", rd, 32'h4);
      apb(1'h1, 12'h010, 32'h4);
      cyc(2);
      chk("irq", irq, 1'h0);
      apb(1'h1, 12'h014, 32'h0);
      pulse(3'h2);
      cyc(3);
      chk("masked irq", {irq, err}, 2'h1);
      apb(1'h0, 12'h010, 32'h0);
      chk("event status", rd, 32'h8);
      pulse(3'h1);
      cyc(3);
      chk("brief flash", err, 1'h1);
      cyc(500 * UC + 20);
      chk("brief flash end", err, 1'h0);
      $display("error test done");
      fatal <= 1'h1;
      sreq <= 1'h1;
      nb = 0;
      ne = 0;
      pb = busy;
      pe = err;
      for (i = 0; i < 2 * 1250 * UC + 40; i++)
      begin
         @(posedge pclk);
         nb += (busy !== pb);
         ne += (err !== pe);
         pb = busy;
         pe = err;
      end
      chk("busy flashing", nb >= 2, 1'h1);
      chk("error flashing", ne >= 2, 1'h1);
      fatal <= 1'h0;
      sreq <= 1'h0;
      $display("flash test done");
      apb(1'h0, 12'h01c, 32'h0);
      chk("unmapped error", se, 1'h1);
      chk("unmapped data", rd, 32'h0);
      apb(1'h1, 12'h000, 32'h80);
      cyc(3);
      chk("restart lamps", {busy, err, grn, yel, red}, 32'h1a);
      $display("restart test done");
      am <= 1'h1;
      apb(1'h1, 12'h000, 32'h340);
      cyc(16 * UC);
      apb(1'h0, 12'h018, 32'h0);
      chk("average", rd[31:16], (6 * 16'h1001 + 4) / 4);
      $display("average test done");
      complete_run;
   end
endmodule : testbench
